/* hw/pci_regs.svh */
`ifndef PCI_REGS_SVH
`define PCI_REGS_SVH

// Frame layout: byte positions inside the nine-byte command frame.
`define PCI_FRAME_LAST   4'h8
`define PCI_POS_ADDR     4'h0
`define PCI_POS_OP       4'h1
`define PCI_POS_TYPE     4'h2
`define PCI_POS_BANK     4'h3
`define PCI_POS_VAL3     4'h4
`define PCI_POS_CSUM     4'h8

// Instruction codes handled by this block.
`define PCI_OP_SET_AXIS  8'h05
`define PCI_OP_GET_AXIS  8'h06
`define PCI_OP_STO_AXIS  8'h07
`define PCI_OP_RST_AXIS  8'h08
`define PCI_OP_SET_GLOB  8'h09
`define PCI_OP_GET_GLOB  8'h0A
`define PCI_OP_STO_GLOB  8'h0B

// Global parameter banks.
`define PCI_BANK_MODULE  8'h00
`define PCI_BANK_USER    8'h02
`define PCI_BANK_IRQ     8'h03

// Reply status codes.
`define PCI_ST_OK        8'h64
`define PCI_ST_BAD_CSUM  8'h01
`define PCI_ST_BAD_CMD   8'h02
`define PCI_ST_BAD_TYPE  8'h03
`define PCI_ST_BAD_VALUE 8'h04

// Non-volatile address regions, upper two bits of the address.
`define PCI_NV_AXIS      2'h1

// Defaults of the module parameters.
`define PCI_NUM_AXIS     16
`define PCI_NUM_GLOBAL   16
`define PCI_MODULE_ADDR  8'h01

// Inter-byte gap after which a partial frame is dropped.
`define PCI_CLK_PERIOD_NS 25
`define PCI_RX_GAP_US     10
`define PCI_RX_GAP_CYC    ((`PCI_RX_GAP_US * 1000) / `PCI_CLK_PERIOD_NS)

`endif

/* hw/pci_pkg.sv */
package pci_pkg;

   // Interpreter sequence, one-hot.
   typedef enum logic [4:0] {
      PCI_LOAD  = 5'h01,
      PCI_IDLE  = 5'h02,
      PCI_EXEC  = 5'h04,
      PCI_NVACC = 5'h08,
      PCI_REPLY = 5'h10
   } pci_state_t;

endpackage

/* hw/pci_cmd_interp.sv */
// How it works
// RULE_01 - Code 5 writes the value into the typed axis parameter, replies OK.
// RULE_02 - Code 6 in direct mode replies the parameter, accumulator untouched.
// RULE_03 - In standalone mode a parameter read also loads the accumulator.
// RULE_04 - Code 7 saves the axis parameter to non-volatile memory, replies OK, zero.
// RULE_05 - Code 8 reloads the axis parameter from its non-volatile copy.
// RULE_06 - After reset every axis parameter is loaded from non-volatile memory.
// RULE_07 - Codes 9 and 10 pick bank 0, 2 or 3 from the motor/bank byte.
// RULE_08 - Any bank 0 global write is saved to non-volatile memory at once.
// RULE_09 - Code 10 reads the global parameter and copies it to the accumulator.
// RULE_10 - Get replies carry the value with status 100; others carry zero.
// RULE_11 - Store-global copies the selected global parameter to non-volatile memory.
// RULE_12 - Frame is address, code, type, bank, four value bytes MSB first, checksum.
// RULE_13 - Code 11 ignores the value field and replies OK with value zero.
// RULE_14 - Checksum is the modulo-256 sum of the first eight bytes.
`include "pci_regs.svh"

module pci_cmd_interp #(
   parameter int         NUM_AXIS    = `PCI_NUM_AXIS,
   parameter int         NUM_GLOBAL  = `PCI_NUM_GLOBAL,
   parameter logic [7:0] MODULE_ADDR = `PCI_MODULE_ADDR
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxValid,
   output wire logic        rxReady,
   input  wire logic        standalone,
   output wire logic        replyValid,
   input  wire logic        replyReady,
   output logic      [7:0]  replyStatus,
   output logic      [7:0]  replyOp,
   output logic      [31:0] replyValue,
   output logic      [31:0] accum,
   output logic             bootDone,
   output wire logic        nvReq,
   output logic             nvWrite,
   output logic      [9:0]  nvAddr,
   output logic      [31:0] nvWdata,
   input  wire logic        nvAck,
   input  wire logic [31:0] nvRdata
);

   localparam int         AW       = $clog2(NUM_AXIS);
   localparam int         GW       = $clog2(NUM_GLOBAL);
   localparam logic [8:0] AXIS_LIM = 9'(NUM_AXIS);
   localparam logic [8:0] GLOB_LIM = 9'(NUM_GLOBAL);
   localparam logic [7:0] LOAD_END = 8'(NUM_AXIS - 1);
   localparam int         GAP_CYC  = `PCI_RX_GAP_CYC;
   localparam logic [11:0] GAP_END = 12'(GAP_CYC - 1);

   // Tables are indexed by the type byte, so neither may exceed 256 entries.
   generate
      if (NUM_AXIS < 2 || NUM_AXIS > 256 || NUM_GLOBAL < 2 || NUM_GLOBAL > 256) begin : gBad
         $error("pci_cmd_interp: table sizes must lie between 2 and 256.");
      end
      if (GAP_CYC < 1 || GAP_CYC > 4096) begin : gBadGap
         $error("pci_cmd_interp: inter-byte gap count out of range.");
      end
   endgenerate

   pci_pkg::pci_state_t stateQ;
   pci_pkg::pci_state_t stateD;

   logic [3:0]  byteCntQ;
   logic [7:0]  frameQ [0:8];
   logic [11:0] gapCntQ;
   logic [31:0] axisQ [0:NUM_AXIS-1];
   logic [31:0] globQ [0:2][0:NUM_GLOBAL-1];

   // State decode.
   wire inLoad  = (stateQ == pci_pkg::PCI_LOAD);
   wire inIdle  = (stateQ == pci_pkg::PCI_IDLE);
   wire inExec  = (stateQ == pci_pkg::PCI_EXEC);
   wire inNvAcc = (stateQ == pci_pkg::PCI_NVACC);
   wire inReply = (stateQ == pci_pkg::PCI_REPLY);

   // Handshakes with the byte source, the reply sink and the memory.
   assign rxReady    = inIdle;
   assign replyValid = inReply;
   assign nvReq      = inLoad | inNvAcc;

   wire takeByte  = ce & rxValid & rxReady;
   wire frameDone = takeByte & (byteCntQ == `PCI_FRAME_LAST);
   wire gapExpire = (byteCntQ != 4'h0) & (gapCntQ == GAP_END);

   // Bytes are stored in arrival order; a long gap drops a partial frame.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         byteCntQ <= 4'h0;
      end else if (ce) begin
         if (frameDone || (!takeByte && gapExpire)) begin
            byteCntQ <= 4'h0;
         end else if (takeByte) begin
            byteCntQ <= byteCntQ + 4'h1; // RULE_12
         end
      end
   end

   // Each byte lands in the slot that its position in the frame names.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 9; i++) begin
            frameQ[i] <= 8'h00;
         end
      end else if (ce && takeByte) begin
         frameQ[byteCntQ] <= rxByte; // RULE_12
      end
   end

   // Cycles since the last byte of an unfinished frame.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gapCntQ <= 12'h000;
      end else if (ce) begin
         if (takeByte || byteCntQ == 4'h0 || gapExpire) begin
            gapCntQ <= 12'h000;
         end else begin
            gapCntQ <= gapCntQ + 12'h001;
         end
      end
   end

   // Frame fields.
   wire [7:0]  addrB = frameQ[`PCI_POS_ADDR];
   wire [7:0]  opB   = frameQ[`PCI_POS_OP];
   wire [7:0]  typeB = frameQ[`PCI_POS_TYPE];
   wire [7:0]  bankB = frameQ[`PCI_POS_BANK];
   wire [31:0] valW  = {frameQ[4], frameQ[5], frameQ[6], frameQ[7]}; // RULE_12

   // Running modulo-256 sum of the first eight bytes.
   wire [7:0] partSum [0:8];
   assign partSum[0] = 8'h00;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : gSum
         assign partSum[gi+1] = 8'(partSum[gi] + frameQ[gi]); // RULE_14
      end
   endgenerate
   wire csOk    = (partSum[8] == frameQ[`PCI_POS_CSUM]); // RULE_14
   wire addrHit = (addrB == MODULE_ADDR);

   // Instruction decode.
   wire isSetAx = (opB == `PCI_OP_SET_AXIS);
   wire isGetAx = (opB == `PCI_OP_GET_AXIS);
   wire isStoAx = (opB == `PCI_OP_STO_AXIS);
   wire isRstAx = (opB == `PCI_OP_RST_AXIS);
   wire isSetGl = (opB == `PCI_OP_SET_GLOB);
   wire isGetGl = (opB == `PCI_OP_GET_GLOB);
   wire isStoGl = (opB == `PCI_OP_STO_GLOB);
   wire isAxOp  = isSetAx | isGetAx | isStoAx | isRstAx;
   wire isGlOp  = isSetGl | isGetGl | isStoGl;

   // Bank selection from the motor/bank byte; banks 0, 2, 3 map to rows 0, 1, 2.
   wire isBank0 = (bankB == `PCI_BANK_MODULE);
   wire bankOk  = isBank0 | (bankB == `PCI_BANK_USER) | (bankB == `PCI_BANK_IRQ); // RULE_07
   wire [1:0] gRow = isBank0 ? 2'h0 : 2'(bankB[1:0] - 2'h1); // RULE_07

   // Parameter selection by the type byte.
   wire typeOkAx = ({1'b0, typeB} < AXIS_LIM);
   wire typeOkGl = ({1'b0, typeB} < GLOB_LIM);
   wire [AW-1:0] axIdx = typeB[AW-1:0];
   wire [GW-1:0] glIdx = typeB[GW-1:0];
   wire [31:0] axRd = axisQ[axIdx];
   wire [31:0] glRd = (gRow == 2'h3) ? 32'h0000_0000 : globQ[gRow][glIdx];

   // Status: checksum first, then code, then type, then motor or bank.
   wire badType  = isAxOp ? !typeOkAx : !typeOkGl;
   wire badValue = isAxOp ? !isBank0 : !bankOk;
   wire [7:0] statusW = !csOk               ? `PCI_ST_BAD_CSUM :
                        !(isAxOp | isGlOp) ? `PCI_ST_BAD_CMD :
                        badType             ? `PCI_ST_BAD_TYPE :
                        badValue            ? `PCI_ST_BAD_VALUE :
                                              `PCI_ST_OK;
   wire cmdOk  = (statusW == `PCI_ST_OK);
   wire execOk = inExec & addrHit & cmdOk;

   // Only gets return data; set, store and restore reply zero.
   wire [31:0] replyValW = !cmdOk  ? 32'h0000_0000 :
                           isGetAx ? axRd :         // RULE_02
                           isGetGl ? glRd :         // RULE_09
                                     32'h0000_0000; // RULE_10

   // Memory traffic: stores, restores and bank 0 writes.
   wire autoSave = isSetGl & isBank0; // RULE_08
   wire needNv   = cmdOk & (isStoAx | isRstAx | isStoGl | autoSave);
   wire [1:0]  nvRegion = isAxOp ? `PCI_NV_AXIS : bankB[1:0];
   wire [31:0] nvDataW  = isSetGl ? valW : (isStoAx ? axRd : glRd); // RULE_04 RULE_11
   wire loadLast = (nvAddr[7:0] == LOAD_END);

   // Sequence control.
   always_comb begin
      stateD = stateQ;
      unique case (stateQ)
         pci_pkg::PCI_LOAD: begin
            if (nvAck && loadLast) begin
               stateD = pci_pkg::PCI_IDLE; // RULE_06
            end
         end
         pci_pkg::PCI_IDLE: begin
            if (frameDone) begin
               stateD = pci_pkg::PCI_EXEC;
            end
         end
         pci_pkg::PCI_EXEC: begin
            if (!addrHit) begin
               stateD = pci_pkg::PCI_IDLE;
            end else if (needNv) begin
               stateD = pci_pkg::PCI_NVACC;
            end else begin
               stateD = pci_pkg::PCI_REPLY;
            end
         end
         pci_pkg::PCI_NVACC: begin
            if (nvAck) begin
               stateD = pci_pkg::PCI_REPLY;
            end
         end
         pci_pkg::PCI_REPLY: begin
            if (replyReady) begin
               stateD = pci_pkg::PCI_IDLE;
            end
         end
         default: begin
            stateD = pci_pkg::PCI_LOAD;
         end
      endcase
   end

   // The sequence starts by loading the axis table.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stateQ <= pci_pkg::PCI_LOAD; // RULE_06
      end else if (ce) begin
         stateQ <= stateD;
      end
   end

   // Axis table: boot load, restore, or a set from the host.
   wire axFromNv = nvAck & (inLoad | (inNvAcc & !nvWrite));
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NUM_AXIS; i++) begin
            axisQ[i] <= 32'h0000_0000;
         end
      end else if (ce) begin
         if (axFromNv) begin
            axisQ[nvAddr[AW-1:0]] <= nvRdata; // RULE_05 RULE_06
         end else if (execOk && isSetAx) begin
            axisQ[axIdx] <= valW; // RULE_01
         end
      end
   end

   // Global banks: a set writes the selected row and entry.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int b = 0; b < 3; b++) begin
            for (int i = 0; i < NUM_GLOBAL; i++) begin
               globQ[b][i] <= 32'h0000_0000;
            end
         end
      end else if (ce && execOk && isSetGl) begin
         globQ[gRow][glIdx] <= valW; // RULE_07
      end
   end

   // Accumulator: global reads always, axis reads only when standalone.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accum <= 32'h0000_0000;
      end else if (ce && execOk && (isGetGl || (isGetAx && standalone))) begin
         accum <= replyValW; // RULE_02 RULE_03 RULE_09
      end
   end

   // Reply fields are captured when the frame is interpreted.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         replyStatus <= 8'h00;
         replyOp     <= 8'h00;
         replyValue  <= 32'h0000_0000;
      end else if (ce && inExec && addrHit) begin
         replyStatus <= statusW; // RULE_10 RULE_13
         replyOp     <= opB;
         replyValue  <= replyValW; // RULE_10 RULE_13
      end
   end

   // Memory request: walks the axis region at boot, else one access.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nvWrite <= 1'b0;
         nvAddr  <= {`PCI_NV_AXIS, 8'h00};
         nvWdata <= 32'h0000_0000;
      end else if (ce) begin
         if (inLoad && nvAck) begin
            nvAddr <= {`PCI_NV_AXIS, 8'(nvAddr[7:0] + 8'h01)}; // RULE_06
         end else if (execOk && needNv) begin
            nvWrite <= !isRstAx; // RULE_04 RULE_05 RULE_08 RULE_11
            nvAddr  <= {nvRegion, typeB};
            nvWdata <= nvDataW;
         end
      end
   end

   // Boot completion flag.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bootDone <= 1'b0;
      end else if (ce && inLoad && nvAck && loadLast) begin
         bootDone <= 1'b1;
      end
   end

endmodule

/* test/pci_nv_model.sv */
// Behavioural non-volatile store with an adjustable answer delay.
module pci_nv_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        slow,
   input  wire logic        nvReq,
   input  wire logic        nvWrite,
   input  wire logic [9:0]  nvAddr,
   input  wire logic [31:0] nvWdata,
   output logic             nvAck,
   output logic      [31:0] nvRdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] mem [1024];
   logic [3:0]  waitQ;
   // Each word starts as a pattern made from its own address.
   initial for (int i = 0; i < 1024; i++) mem[i] = {8'hC3, 14'h0, i[9:0]};
   // One ack per request; read data is toggled outside the ack cycle.
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         nvAck <= 1'b0;
         waitQ <= 4'h0;
         nvRdata <= 32'h0;
      end else begin
         nvAck <= 1'b0;
         nvRdata <= ~nvRdata;
         if (nvReq && !nvAck) begin
            if (waitQ == (slow ? 4'h5 : 4'h0)) begin
               nvAck <= 1'b1;
               waitQ <= 4'h0;
               if (nvWrite) mem[nvAddr] <= nvWdata;
               else nvRdata <= mem[nvAddr];
            end else waitQ <= waitQ + 4'h1;
         end
      end
   end
endmodule

/* test/pci_cmd_interp_monitor.sv */
`include "pci_regs.svh"

// Timing relations between the interpreter's ports.
module pci_cmd_interp_monitor (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        standalone,
   input wire logic        rxReady,
   input wire logic        replyValid,
   input wire logic        replyReady,
   input wire logic [7:0]  replyStatus,
   input wire logic [7:0]  replyOp,
   input wire logic [31:0] replyValue,
   input wire logic [31:0] accum,
   input wire logic        bootDone,
   input wire logic        nvReq,
   input wire logic        nvWrite,
   input wire logic [9:0]  nvAddr,
   input wire logic [31:0] nvWdata,
   input wire logic        nvAck
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // A successful reply is on the port.
   wire ok = replyValid && replyStatus == `PCI_ST_OK;
   // Checks.
   a_idle_only: assert property (rxReady |-> !replyValid && !nvReq)
      else $error("byte link ready outside idle");
   a_reply_holds: assert property (replyValid && !replyReady |=>
      replyValid && $stable(replyValue) && $stable(replyStatus)) else $error("reply moved");
   a_nv_holds: assert property (nvReq && !nvAck |=> nvReq && $stable(nvAddr)
      && $stable(nvWdata) && $stable(nvWrite)) else $error("memory request moved");
   a_boot_reads: assert property (nvReq && !bootDone |->
      !nvWrite && nvAddr[9:8] == `PCI_NV_AXIS) else $error("boot access wrong");
   a_boot_ready: assert property ($rose(bootDone) |-> ##[0:1] rxReady)
      else $error("not ready after boot");
   a_ack_reply: assert property (nvAck && nvReq && bootDone |=> replyValid)
      else $error("no reply after memory ack");
   a_other_zero: assert property (ok && replyOp inside {8'h05, 8'h07, 8'h08, 8'h09,
      8'h0B} |-> replyValue == 32'h0) else $error("non-get reply value not zero");
   a_sa_accum: assert property (ok && standalone && replyOp == `PCI_OP_GET_AXIS
      |-> accum == replyValue) else $error("standalone get left accumulator");
   a_glob_accum: assert property (ok && replyOp == `PCI_OP_GET_GLOB
      |-> accum == replyValue) else $error("global get left accumulator");
   // Main scenarios reached.
   c_store: cover property (ok && replyOp == `PCI_OP_STO_AXIS);
   c_error: cover property (replyValid && replyStatus != `PCI_ST_OK);
   c_boot: cover property ($rose(bootDone));
endmodule

bind pci_cmd_interp pci_cmd_interp_monitor MON (.clk(clk), .arst_n(arst_n),
   .standalone(standalone), .rxReady(rxReady), .replyValid(replyValid),
   .replyReady(replyReady), .replyStatus(replyStatus), .replyOp(replyOp),
   .replyValue(replyValue), .accum(accum), .bootDone(bootDone), .nvReq(nvReq),
   .nvWrite(nvWrite), .nvAddr(nvAddr), .nvWdata(nvWdata), .nvAck(nvAck));

/* test/pci_cmd_interp_tb.sv */
`include "pci_regs.svh"
`define CHK(nm, ex, got) begin \
   total_checks++; \
   if ((got) !== (ex)) begin \
      n_errors++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end \
end

module pci_cmd_interp_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, arst_n = 1'b0, rxValid = 1'b0, standalone = 1'b0;
   logic        replyReady = 1'b0, slow = 1'b0, gotR;
   logic [7:0]  rxByte = 8'h00, rs, ro;
   logic [31:0] rv;
   wire logic   rxReady, replyValid, bootDone, nvReq, nvWrite, nvAck;
   wire logic [7:0]  replyStatus, replyOp;
   wire logic [31:0] replyValue, accum, nvWdata, nvRdata;
   wire logic [9:0]  nvAddr;
   int          n_errors = 0, total_checks = 0;
   // Design and its memory partner.
   pci_cmd_interp DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1), .rxByte(rxByte),
      .rxValid(rxValid), .rxReady(rxReady), .standalone(standalone),
      .replyValid(replyValid), .replyReady(replyReady), .replyStatus(replyStatus),
      .replyOp(replyOp), .replyValue(replyValue), .accum(accum), .bootDone(bootDone),
      .nvReq(nvReq), .nvWrite(nvWrite), .nvAddr(nvAddr), .nvWdata(nvWdata),
      .nvAck(nvAck), .nvRdata(nvRdata));
   pci_nv_model NV (.clk(clk), .arst_n(arst_n), .slow(slow), .nvReq(nvReq),
      .nvWrite(nvWrite), .nvAddr(nvAddr), .nvWdata(nvWdata), .nvAck(nvAck),
      .nvRdata(nvRdata));
   // Clock at 40 MHz.
   always #12.5 clk = ~clk;
   // Sends one frame, then waits up to 40 cycles for its reply and accepts it.
   task automatic frame(input logic [7:0] ad, op, ty, bk, input logic [31:0] v,
                        input logic [7:0] adj);
      logic [7:0] b [9];
      b = '{ad, op, ty, bk, v[31:24], v[23:16], v[15:8], v[7:0], adj};
      for (int i = 0; i < 8; i++) b[8] += b[i];
      for (int i = 0; i < 9; i++) begin
         rxByte <= b[i];
         rxValid <= 1'b1;
         do @(posedge clk); while (rxReady !== 1'b1);
      end
      rxValid <= 1'b0;
      gotR = 1'b0;
      for (int i = 0; i < 40 && !gotR; i++) begin
         @(posedge clk);
         gotR = (replyValid === 1'b1);
      end
      if (gotR) begin
         rs = replyStatus;
         ro = replyOp;
         rv = replyValue;
         replyReady <= 1'b1;
         @(posedge clk);
         replyReady <= 1'b0;
      end
   endtask
   // Axis command to this module.
   task automatic ax(input logic [7:0] op, ty, input logic [31:0] v);
      frame(8'h01, op, ty, 8'h00, v, 8'h00);
   endtask
   // Boot load and direct-mode read.
   task automatic t_boot;
      ax(`PCI_OP_GET_AXIS, 8'h03, 32'hFFFFFFFF);
      `CHK("boot status", `PCI_ST_OK, rs);
      `CHK("boot value", 32'hC3000103, rv);
      `CHK("boot done", 1'b1, bootDone);
      `CHK("reply code", `PCI_OP_GET_AXIS, ro);
      `CHK("direct accum", 32'h0, accum);
   endtask
   // Write then read back an axis parameter.
   task automatic t_set_get;
      ax(`PCI_OP_SET_AXIS, 8'h05, 32'h12345678);
      `CHK("set status", `PCI_ST_OK, rs);
      ax(`PCI_OP_GET_AXIS, 8'h05, 32'h0);
      `CHK("get value", 32'h12345678, rv);
      `CHK("accum kept", 32'h0, accum);
   endtask
   // Save, overwrite and reload through a slow memory.
   task automatic t_store_restore;
      slow <= 1'b1;
      ax(`PCI_OP_STO_AXIS, 8'h05, 32'hDEADBEEF);
      `CHK("store value", 32'h0, rv);
      `CHK("nv copy", 32'h12345678, NV.mem[10'h105]);
      ax(`PCI_OP_SET_AXIS, 8'h05, 32'h00000055);
      ax(`PCI_OP_RST_AXIS, 8'h05, 32'hDEADBEEF);
      `CHK("restore status", `PCI_ST_OK, rs);
      ax(`PCI_OP_GET_AXIS, 8'h05, 32'h0);
      `CHK("restored", 32'h12345678, rv);
      slow <= 1'b0;
   endtask
   // Stored-program read loads the accumulator.
   task automatic t_standalone;
      standalone <= 1'b1;
      ax(`PCI_OP_GET_AXIS, 8'h05, 32'h0);
      `CHK("program accum", 32'h12345678, accum);
      standalone <= 1'b0;
   endtask
   // All banks, bank 0 persistence and the user variable store.
   task automatic t_global;
      logic [7:0] bk [3];
      bk = '{`PCI_BANK_MODULE, `PCI_BANK_USER, `PCI_BANK_IRQ};
      for (int i = 0; i < 3; i++) begin
         frame(8'h01, `PCI_OP_SET_GLOB, 8'h01, bk[i], {28'hB000000, i[3:0]}, 8'h00);
         `CHK("global set", `PCI_ST_OK, rs);
         frame(8'h01, `PCI_OP_GET_GLOB, 8'h01, bk[i], 32'hFFFFFFFF, 8'h00);
         `CHK("global get", {28'hB000000, i[3:0]}, rv);
         `CHK("global accum", {28'hB000000, i[3:0]}, accum);
      end
      `CHK("bank0 saved", 32'hB0000000, NV.mem[10'h001]);
      `CHK("bank3 unsaved", 32'hC3000301, NV.mem[10'h301]);
      frame(8'h01, `PCI_OP_STO_GLOB, 8'h01, `PCI_BANK_USER, 32'hDEADBEEF, 8'h00);
      `CHK("gstore value", 32'h0, rv);
      `CHK("user saved", 32'hB0000001, NV.mem[10'h201]);
   endtask
   // Refused frames leave axis parameter 5 alone.
   task automatic t_errors;
      frame(8'h01, `PCI_OP_SET_AXIS, 8'h05, 8'h00, 32'h0, 8'h01);
      `CHK("bad sum", `PCI_ST_BAD_CSUM, rs);
      frame(8'h01, 8'h03, 8'h00, 8'h00, 32'h0, 8'h00);
      `CHK("bad code", `PCI_ST_BAD_CMD, rs);
      frame(8'h01, `PCI_OP_SET_GLOB, 8'h01, 8'h01, 32'h0, 8'h00);
      `CHK("bad bank", `PCI_ST_BAD_VALUE, rs);
      frame(8'h01, `PCI_OP_SET_AXIS, 8'h10, 8'h00, 32'h0, 8'h00);
      `CHK("bad type", `PCI_ST_BAD_TYPE, rs);
      frame(8'h02, `PCI_OP_SET_AXIS, 8'h05, 8'h00, 32'h0, 8'h00);
      `CHK("other address", 1'b0, gotR);
      ax(`PCI_OP_GET_AXIS, 8'h05, 32'h0);
      `CHK("untouched", 32'h12345678, rv);
   endtask
   // Verdict and end of run.
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog against a hang.
   initial begin
      #(25 * 6000);
      n_errors++;
      end_of_test();
   end
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_boot();
      t_set_get();
      t_store_restore();
      t_standalone();
      t_global();
      t_errors();
      end_of_test();
   end
endmodule
